// ### gate_seq_pkg.sv
// package: states, modes and timing constants of the gate sequencer
package gate_seq_pkg;

    typedef enum logic [1:0] {
        st_startup,
        st_low_freq,
        st_normal,
        st_overvolt
    } seq_state_t;

    typedef enum logic [1:0] {
        mode_iso_cot,
        mode_iso_pcm,
        mode_niso_cot,
        mode_reserved
    } op_mode_t;

    localparam int    CLK_HZ          = 40_000_000;
    localparam real   LF_ON_TIME_US   = 1.5;
    localparam real   LF_OFF_TIME_US  = 72.0;
    localparam int    DELAY_MULT      = 2;
    localparam int    OVP_CYCLES      = 3;
    // fixed low-frequency times in clock cycles, rounded down
    localparam int    LF_ON_CYCLES    =
        int'($floor(LF_ON_TIME_US * CLK_HZ / 1.0e6));
    localparam int    LF_OFF_CYCLES   =
        int'($floor(LF_OFF_TIME_US * CLK_HZ / 1.0e6));
    localparam int    TIMER_W         = 16;
    localparam int    DLY_W           = 12;
    localparam logic [1:0] OVP_CNT_RST = 2'h0;

endpackage

// ### sync_bus_if.sv
// interface: synchronised comparator levels passed to the sequencer core
`timescale 1ns/1ps
interface sync_bus_if;
    logic [9:0] raw;
    logic [9:0] level;
    modport sync_side (input raw, output level);
    modport user_side (output raw, input level);
endinterface

// ### level_sync.sv
// module: three-flop synchroniser bank for asynchronous comparator inputs
`timescale 1ns/1ps
module level_sync
#(
    parameter int W = 10
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // levels
    sync_bus_if.sync_side bus
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } sync_state_t;

    sync_state_t q;
    sync_state_t next_q;

    always_comb
    begin
        next_q    = q;
        next_q.s1 = bus.raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        // change counts once the second and third stage agree
        for (int i = 0; i < W; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                next_q.level[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign bus.level = q.level;
endmodule

// ### flyback_gate_sequencer.sv
// module: switching-cycle controller for a primary-side-sensed flyback
//
// Notes on behaviour
// RULE1: startup keeps gate low, logic idle
// RULE2: lockout release enters low-frequency 1.5us/72us
// RULE3: arm threshold crossed moves to normal operation
// RULE4: straps decode to iso cot, iso pcm, niso cot
// RULE5: board never grounds both straps nor drives them
// RULE6: mode latched only at lockout release
// RULE7: non-isolated topology allows fixed on-time only
// RULE8: wait twice programmed delay after zero cross
// RULE9: fixed on-time ends on ramp crossing compensation
// RULE10: peak-current ends on sense reaching threshold
// RULE11: zero cross ends the off-period
// RULE12: over-voltage after three consecutive high cycles
// RULE13: over-voltage state stops all switching
// RULE14: lockout fall in over-voltage returns to startup
// RULE15: peak below trigger reverts to low-frequency
// RULE16: short cleared in low-frequency returns to normal
// RULE17: persisting short until lockout fall restarts
// RULE18: over-current drops gate at once
// RULE19: thermal indication forces gate low, stops switching
// RULE20: thermal clear resumes operation
// RULE21: all comparator results synchronised before use
`timescale 1ns/1ps
module flyback_gate_sequencer
    import gate_seq_pkg::*;
#(
    parameter int LF_ON  = LF_ON_CYCLES,
    parameter int LF_OFF = LF_OFF_CYCLES
)
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // strap pins, low when grounded
    input  wire logic                          mode_strap_a,
    input  wire logic                          mode_strap_b,
    // comparator results from the analog front end
    input  wire logic                          supply_ok,
    input  wire logic                          zero_cross_input,
    input  wire logic                          aux_above_arm,
    input  wire logic                          aux_above_trigger,
    input  wire logic                          aux_above_ovp,
    input  wire logic                          sense_at_peak,
    input  wire logic                          sense_at_ocp,
    input  wire logic                          ramp_cross_comp,
    input  wire logic                          thermal_hot,
    // turn-on delay in units of two clock cycles, from the delay resistor
    input  wire logic [DLY_W-1:0]              delay_program_input,
    // gate drive and status
    output logic                               gate,
    output gate_seq_pkg::seq_state_t           state,
    output gate_seq_pkg::op_mode_t             op_mode,
    output logic                               thermal_shutdown,
    output logic                               ocp_event
);
    import gate_seq_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    sync_bus_if sb ();

    assign sb.raw = {mode_strap_b, mode_strap_a, thermal_hot,
                     ramp_cross_comp, sense_at_ocp, sense_at_peak,
                     aux_above_ovp, aux_above_trigger, aux_above_arm,
                     zero_cross_input};

    level_sync #(.W(10)) u_sync                 // see RULE21
    (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (sb)
    );

    logic zc;
    logic arm;
    logic trig;
    logic ovp_hi;
    logic pk;
    logic overcurrent_protect;
    logic ramp;
    logic hot;
    logic strap_a;
    logic strap_b;
    logic sup;

    assign {strap_b, strap_a, hot, ramp, overcurrent_protect, pk, ovp_hi, trig, arm, zc}
        = sb.level;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ph_on,
        ph_off,
        ph_delay
    } phase_t;

    typedef struct packed {
        seq_state_t         st;
        op_mode_t           mode;
        phase_t             ph;
        logic [TIMER_W-1:0] tmr;
        logic [1:0]         ovp_cnt;
        logic               ovp_seen;
        logic               gate;
        logic               hot;
        logic               sup_d;
        logic               ocp_ev;
        logic [2:0]         sup_sr;
        logic               sup_lvl;
    } core_t;

    core_t q;
    core_t next_q;

    // supply lockout rides its own chain inside the state
    assign sup = q.sup_lvl;

    // decoded strap mode; both grounded is reserved
    op_mode_t strap_mode;
    always_comb
    begin
        case ({strap_a, strap_b})                // see RULE4
            2'b11:   strap_mode = mode_iso_cot;
            2'b01:   strap_mode = mode_iso_pcm;
            2'b10:   strap_mode = mode_niso_cot;
            // reserved strapping falls back to fixed on-time
            default: strap_mode = mode_reserved; // see RULE5
        endcase
    end

    logic [TIMER_W-1:0] delay_cycles;
    assign delay_cycles = TIMER_W'(DELAY_MULT) *
                          TIMER_W'(delay_program_input); // see RULE8

    logic on_done;
    always_comb
    begin
        // peak-current only with isolated pcm strapping
        if (q.mode == mode_iso_pcm)              // see RULE7
        begin
            on_done = pk;                        // see RULE10
        end
        else
        begin
            on_done = ramp;                      // see RULE9
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_q        = q;
        next_q.sup_d  = sup;
        next_q.ocp_ev = 1'b0;
        next_q.hot    = hot;                     // see RULE19
        next_q.sup_sr = {q.sup_sr[1:0], supply_ok};
        if (q.sup_sr[1] == q.sup_sr[2])
        begin
            next_q.sup_lvl = q.sup_sr[2];        // see RULE21
        end

        case (q.st)
            st_startup:
            begin
                next_q.gate = 1'b0;              // see RULE1
                next_q.tmr  = '0;
                next_q.ph   = ph_on;
                next_q.ovp_cnt  = OVP_CNT_RST;
                next_q.ovp_seen = 1'b0;
                if (sup && !q.sup_d)
                begin
                    next_q.mode = strap_mode;    // see RULE6
                    next_q.st   = st_low_freq;   // see RULE2
                    next_q.gate = 1'b1;
                end
            end
            st_low_freq:
            begin
                next_q.tmr = q.tmr + 1'b1;
                if (q.ph == ph_on)
                begin
                    if (q.tmr >= TIMER_W'(LF_ON - 1))
                    begin
                        next_q.gate = 1'b0;      // see RULE2
                        next_q.ph   = ph_off;
                        next_q.tmr  = '0;
                    end
                end
                else if (q.tmr >= TIMER_W'(LF_OFF - 1))
                begin
                    next_q.gate = 1'b1;
                    next_q.ph   = ph_on;
                    next_q.tmr  = '0;
                end
                if (arm)
                begin
                    // short cleared or armed: steady state
                    next_q.st   = st_normal;     // see RULE3 RULE16
                    next_q.gate = 1'b0;
                    next_q.ph   = ph_off;
                    next_q.tmr  = '0;
                end
            end
            st_normal:
            begin
                next_q.tmr = q.tmr + 1'b1;
                case (q.ph)
                    ph_on:
                    begin
                        if (on_done)
                        begin
                            next_q.gate = 1'b0;
                            next_q.ph   = ph_off;
                            next_q.ovp_seen = 1'b0;
                        end
                    end
                    ph_off:
                    begin
                        if (ovp_hi)
                        begin
                            next_q.ovp_seen = 1'b1;
                        end
                        if (!trig && !zc && q.ovp_seen == 1'b0 && !arm
                            && q.tmr >= TIMER_W'(LF_OFF - 1))
                        begin
                            // aux peak below trigger: output short
                            next_q.st  = st_low_freq; // see RULE15
                            next_q.ph  = ph_off;
                            next_q.tmr = '0;
                        end
                        else if (zc)
                        begin
                            next_q.ph  = ph_delay;    // see RULE11
                            next_q.tmr = '0;
                            // count cycles with aux above limit
                            if (q.ovp_seen || ovp_hi)
                            begin
                                next_q.ovp_cnt = q.ovp_cnt + 1'b1;
                            end
                            else
                            begin
                                next_q.ovp_cnt = OVP_CNT_RST;
                            end
                            if ((q.ovp_seen || ovp_hi) &&
                                q.ovp_cnt == 2'(OVP_CYCLES - 1))
                            begin
                                next_q.st = st_overvolt; // see RULE12
                            end
                        end
                    end
                    ph_delay:
                    begin
                        if (q.tmr + 1'b1 >= delay_cycles)
                        begin
                            next_q.gate = 1'b1;      // see RULE8
                            next_q.ph   = ph_on;
                            next_q.tmr  = '0;
                        end
                    end
                    default:
                    begin
                        next_q.ph = ph_off;
                    end
                endcase
            end
            st_overvolt:
            begin
                next_q.gate = 1'b0;              // see RULE13
            end
            default:
            begin
                next_q.st = st_startup;
            end
        endcase

        // over-current ends the on-period at once
        if (q.gate && overcurrent_protect)
        begin
            next_q.gate   = 1'b0;                // see RULE18
            next_q.ocp_ev = 1'b1;
            if (q.st == st_normal)
            begin
                next_q.ph = ph_off;
            end
        end

        // hot: hold gate low; timers resume on clear
        if (hot)
        begin
            next_q.gate = 1'b0;                  // see RULE19 RULE20
            next_q.tmr  = q.tmr;
            next_q.ph   = (q.st == st_normal) ? ph_off : q.ph;
        end

        // lockout fall restarts from any running state
        if (!sup && q.st != st_startup)
        begin
            next_q.st   = st_startup;            // see RULE14 RULE17
            next_q.gate = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '{st: st_startup, mode: mode_iso_cot, ph: ph_on,
                   default: '0};
        end
        else
        begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // combinational kill path keeps ocp and thermal immediate
    assign gate             = q.gate && !overcurrent_protect && !hot;   // see RULE18
    assign state            = q.st;
    assign op_mode          = q.mode;
    assign thermal_shutdown = q.hot;
    assign ocp_event        = q.ocp_ev;
endmodule

// ### flyback_gate_sequencer_properties.sv
// checker: port-level properties of the flyback gate sequencer
`timescale 1ns/1ps
module flyback_gate_checker
    import gate_seq_pkg::*;
#(
    parameter int LF_ON  = 4,
    parameter int LF_OFF = 20
)
(
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // observed ports
    input wire logic                     supply_ok,
    input wire logic                     gate,
    input wire gate_seq_pkg::seq_state_t state,
    input wire gate_seq_pkg::op_mode_t   op_mode,
    input wire logic                     thermal_shutdown,
    input wire logic                     ocp_event
);
    // ---------------
    // gate run length
    // ---------------
    logic        prev_gate;
    logic        fell_in_lf;
    logic [15:0] run_cnt;

    // off runs count only when the preceding fall was in low-frequency
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev_gate  <= 1'b0;
            fell_in_lf <= 1'b0;
            run_cnt    <= 16'h0;
        end
        else
        begin
            prev_gate <= gate;
            run_cnt   <= (gate != prev_gate) ? 16'h1 : run_cnt + 16'h1;
            if (state != st_low_freq)
                fell_in_lf <= 1'b0;
            else if (prev_gate && !gate)
                fell_in_lf <= 1'b1;
        end
    end

    // ----------
    // properties
    // ----------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_startup_gate_low:
        assert property (state == st_startup |-> !gate)
        else $error("gate high in startup");
    chk_lf_on_len:
        assert property (prev_gate && !gate && state == st_low_freq
            |-> run_cnt == 16'(LF_ON))
        else $error("low-frequency on-time wrong");
    chk_lf_off_len:
        assert property (!prev_gate && gate && fell_in_lf
            && state == st_low_freq |-> run_cnt == 16'(LF_OFF))
        else $error("low-frequency off-time wrong");
    chk_mode_held:
        assert property (state != st_startup && $past(state) != st_startup
            && $past(state, 2) != st_startup |-> $stable(op_mode))
        else $error("mode changed while running");
    chk_ovp_gate_off:
        assert property (state == st_overvolt |-> !gate)
        else $error("gate high in over-voltage");
    chk_ovp_restart:
        assert property (state == st_overvolt && !supply_ok
            |-> ##[1:8] state == st_startup)
        else $error("no restart after supply fall");
    chk_hot_gate_off:
        assert property ($rose(thermal_shutdown) |-> !gate [*4])
        else $error("gate high while hot");
    chk_ocp_pulse:
        assert property (ocp_event |-> !gate ##1 !ocp_event)
        else $error("over-current pulse wrong");

    cov_overvolt: cover property (state == st_overvolt);
    cov_hot: cover property ($rose(thermal_shutdown));
    cov_ocp: cover property (ocp_event);
endmodule

bind flyback_gate_sequencer flyback_gate_checker #(
    .LF_ON  (LF_ON),
    .LF_OFF (LF_OFF)
) u_chk (
    .clk, .rst_n, .supply_ok, .gate, .state, .op_mode,
    .thermal_shutdown, .ocp_event
);

// ### power_stage_model.sv
// model: power stage and aux winding comparators seen from the gate pin
`timescale 1ns/1ps
module power_stage_model
#(
    parameter int RAMP_CYC = 10,
    parameter int PEAK_CYC = 30,
    parameter int ZC_CYC   = 12
)
(
    // clock
    input  wire logic clk,
    // gate drive and fault selection
    input  wire logic gate,
    input  wire logic shorted,
    // comparator results
    output logic      zero_cross_input,
    output logic      aux_above_arm,
    output logic      aux_above_trigger,
    output logic      ramp_cross_comp,
    output logic      sense_at_peak
);
    int hi_cnt = 0;
    int lo_cnt = 0;

    initial
    begin
        zero_cross_input  = 1'b0;
        aux_above_arm     = 1'b0;
        aux_above_trigger = 1'b0;
        ramp_cross_comp   = 1'b0;
        sense_at_peak     = 1'b0;
    end

    // shorted output: aux never rises, so no ringing to detect
    always @(posedge clk)
    begin
        hi_cnt            <= gate ? hi_cnt + 1 : 0;
        lo_cnt            <= gate ? 0 : lo_cnt + 1;
        ramp_cross_comp   <= gate && hi_cnt >= RAMP_CYC;
        sense_at_peak     <= gate && hi_cnt >= PEAK_CYC;
        zero_cross_input  <= !gate && !shorted
                             && lo_cnt >= ZC_CYC;
        aux_above_arm     <= !shorted;
        aux_above_trigger <= !shorted;
    end
endmodule

// ### flyback_gate_sequencer_tb.sv
// testbench: scenario tasks for the gate sequencer and its power stage
`timescale 1ns/1ps
module flyback_gate_sequencer_tb;
    import gate_seq_pkg::*;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             mode_strap_a = 1'b1;
    logic             mode_strap_b = 1'b1;
    logic             supply_ok = 1'b0;
    logic             aux_above_ovp = 1'b0;
    logic             sense_at_ocp = 1'b0;
    logic             thermal_hot = 1'b0;
    logic             shorted = 1'b1;
    logic [DLY_W-1:0] delay_program_input = 12'h005;
    logic             zero_cross_input;
    logic             aux_above_arm;
    logic             aux_above_trigger;
    logic             ramp_cross_comp;
    logic             sense_at_peak;
    logic             gate;
    seq_state_t       state;
    op_mode_t         op_mode;
    logic             thermal_shutdown;
    logic             ocp_event;
    int               mismatches = 0;
    int               cmp_count = 0;

    always #12.5 clk = ~clk;

    // short low-frequency counts keep the run brief
    flyback_gate_sequencer #(.LF_ON(4), .LF_OFF(20)) u_dut (
        .clk, .rst_n, .mode_strap_a, .mode_strap_b, .supply_ok,
        .zero_cross_input, .aux_above_arm, .aux_above_trigger, .aux_above_ovp,
        .sense_at_peak, .sense_at_ocp, .ramp_cross_comp, .thermal_hot,
        .delay_program_input, .gate, .state, .op_mode, .thermal_shutdown,
        .ocp_event);
    power_stage_model u_stage (
        .clk, .gate, .shorted, .zero_cross_input, .aux_above_arm,
        .aux_above_trigger, .ramp_cross_comp, .sense_at_peak);

    // -------
    // helpers
    // -------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wait_st(input seq_state_t s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim)
        begin
            tick(1);
            n++;
        end
        cmp_val(16'(state), 16'(s));
    endtask

    task automatic until_gate(input logic lvl, output int n);
        n = 0;
        while (gate !== lvl && n < 400)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic power_up(input logic a, input logic b);
        mode_strap_a = a;
        mode_strap_b = b;
        shorted = 1'b1;
        supply_ok = 1'b1;
        wait_st(st_low_freq, 20);
    endtask

    task automatic power_down();
        supply_ok = 1'b0;
        wait_st(st_startup, 20);
    endtask

    // ---------
    // scenarios
    // ---------
    task automatic t_modes();
        logic [1:0] sel [3] = '{2'b11, 2'b01, 2'b10};
        op_mode_t   exp [3] = '{mode_iso_cot, mode_iso_pcm, mode_niso_cot};
        for (int i = 0; i < 3; i++)
        begin
            power_up(sel[i][1], sel[i][0]);
            cmp_val(16'(op_mode), 16'(exp[i]));
            {mode_strap_a, mode_strap_b} = sel[(i + 1) % 3];
            tick(60);
            cmp_val(16'(op_mode), 16'(exp[i]));
            power_down();
        end
    endtask

    task automatic t_switch(input logic a, input logic b, input int on);
        int n;
        int d;
        power_up(a, b);
        shorted = 1'b0;
        wait_st(st_normal, 40);
        until_gate(1'b1, n);
        until_gate(1'b0, n);
        cmp_rng(n, on, on + 8);
        n = 0;
        while (zero_cross_input !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        until_gate(1'b1, n);
        d = 2 * delay_program_input;
        cmp_rng(n, d, d + 8);
    endtask

    task automatic t_short();
        shorted = 1'b1;
        wait_st(st_low_freq, 60);
        shorted = 1'b0;
        wait_st(st_normal, 60);
        shorted = 1'b1;
        wait_st(st_low_freq, 60);
        power_down();
    endtask

    task automatic t_ovp();
        int n;
        int k;
        logic p;
        until_gate(1'b1, n);
        aux_above_ovp = 1'b1;
        k = 0;
        p = gate;
        while (state !== st_overvolt && n < 400)
        begin
            tick(1);
            n++;
            k += int'(gate === 1'b1 && p !== 1'b1);
            p = gate;
        end
        cmp_rng(k, 2, 3);
        tick(40);
        cmp_val(16'(gate), 16'h0);
        aux_above_ovp = 1'b0;
        power_down();
    endtask

    task automatic t_hot();
        int n;
        int k;
        until_gate(1'b1, n);
        thermal_hot = 1'b1;
        tick(8);
        cmp_val(16'(thermal_shutdown), 16'h1);
        k = 0;
        repeat (60)
        begin
            tick(1);
            k += int'(gate === 1'b1);
        end
        cmp_val(16'(k), 16'h0);
        thermal_hot = 1'b0;
        until_gate(1'b1, n);
        cmp_rng(n, 1, 80);
        power_down();
    endtask

    task automatic t_ocp();
        int n;
        int k;
        until_gate(1'b1, n);
        tick(2);
        sense_at_ocp = 1'b1;
        k = 0;
        repeat (8)
        begin
            tick(1);
            k += int'(ocp_event === 1'b1);
        end
        sense_at_ocp = 1'b0;
        cmp_val(16'(k), 16'h1);
        cmp_val(16'(gate), 16'h0);
        power_down();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        tick(6);
        cmp_val(16'(gate), 16'h0);
        cmp_val(16'(state), 16'(st_startup));
        cmp_val(16'(op_mode), 16'(mode_iso_cot));
        rst_n = 1'b1;
        tick(4);
        t_modes();
        t_switch(1'b1, 1'b1, 10);
        t_short();
        t_switch(1'b0, 1'b1, 30);
        t_ovp();
        t_switch(1'b1, 1'b0, 10);
        t_hot();
        t_switch(1'b1, 1'b1, 10);
        t_ocp();
        complete_run();
    end

    // hang guard, well beyond the expected thousand or so cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule
